// ---- hdl/tc8_core.sv ----
// 8-bit timer/counter core with two compare units behind APB
`timescale 1ns/1ps
`default_nettype none
module tc8_core #(
    parameter int PRE_W = tc8_pkg::TC8_PRE_W  // Prescaler width
) (
    input  wire logic        pclk,                 // System clock
    input  wire logic        presetn,              // Async reset, low
    input  wire logic        psel,                 // APB select
    input  wire logic        penable,              // APB enable
    input  wire logic        pwrite,               // APB direction
    input  wire logic [7:0]  paddr,                // APB byte address
    input  wire logic [31:0] pwdata,               // APB write data
    output logic      [31:0] prdata,               // APB read data
    output logic             pready,               // APB ready
    output logic             pslverr,              // APB error
    input  wire logic        external_count_input, // Count pin
    input  wire logic [2:0]  int_serviced,         // Service pulses
    output logic      [2:0]  timer_irq_req         // Masked requests
);
    import tc8_pkg::*;

    // Prescaler tap test for internal sources
    function automatic logic presc_tick(input logic [2:0] cs,
                                        input logic [PRE_W-1:0] p);
        logic r;
        r = 1'b0;
        unique case (cs)
            TC8_CS_DIV1:   r = 1'b1;
            TC8_CS_DIV8:   r = &p[2:0];
            TC8_CS_DIV64:  r = &p[5:0];
            TC8_CS_DIV256: r = &p[7:0];
            TC8_CS_DIV1K:  r = &p[9:0];
            default:       r = 1'b0;
        endcase
        return r;
    endfunction

    // Top value of the count sequence for a mode
    function automatic logic [7:0] top_of(input logic [2:0] wm,
                                          input logic [7:0] cmp);
        logic [7:0] t;
        t = TC8_MAX;
        if (wm == TC8_WM_CTC || wm == TC8_WM_PC_CMPA ||
            wm == TC8_WM_FP_CMPA) begin
            t = cmp;
        end
        return t;
    endfunction

    // Configuration and data registers
    tc8_cfg_s         cfg_r,  cfg_nxt;      // Clock select and mode
    logic [7:0]       cnt_r,  cnt_nxt;      // counter_value
    logic [7:0]       cmpa_r, cmpa_nxt;     // compare_value_a
    logic [7:0]       cmpb_r, cmpb_nxt;     // compare_value_b
    logic [2:0]       mask_r, mask_nxt;     // timer_interrupt_mask_reg
    logic [2:0]       flag_r, flag_nxt;     // timer_interrupt_flag_reg
    tc8_dir_e         dir_r,  dir_nxt;      // Count direction
    logic             blk_r,  blk_nxt;      // Match block after write
    // Tick generation state
    logic [PRE_W-1:0] pre_r,  pre_nxt;      // Free-running prescaler
    logic [2:0]       ext_r,  ext_nxt;      // Sync pair plus edge stage
    // Bus answer registers
    logic [31:0]      rd_r,   rd_nxt;       // Read data
    logic             rdy_r,  rdy_nxt;      // Ready
    logic             err_r,  err_nxt;      // Error
    logic [2:0]       irq_r,  irq_nxt;      // Masked request outputs
    // Combinational helpers
    logic             acc_done;             // Access completes now
    logic             wr_en;                // Write completes now
    logic             mapped;               // Address decodes
    logic             timer_tick;           // One count step
    logic             ext_edge;             // Selected pin edge seen
    logic [7:0]       top_val;              // Current top
    logic             at_top;               // Top indication
    logic             at_bottom;            // Bottom indication
    logic             pc_mode;              // Phase correct mode
    logic             fp_mode;              // Fast PWM mode
    logic [2:0]       set_ev;               // Flag set events
    logic [2:0]       clr_ev;               // Flag clear requests

    // Bus decode
    // A transfer completes only in the cycle that shows ready,
    // so each write lands exactly once per access
    always_comb begin
        acc_done = psel & penable & rdy_r;
        wr_en    = acc_done & pwrite;
        unique case (paddr)
            TC8_OFS_CTRL_A, TC8_OFS_CTRL_B, TC8_OFS_COUNT,
            TC8_OFS_CMP_A, TC8_OFS_CMP_B, TC8_OFS_MASK,
            TC8_OFS_FLAG, TC8_OFS_STATUS: mapped = 1'b1;
            default:                      mapped = 1'b0;
        endcase
    end

    // Clock selection and tick generation
    // A pin change needs two edges to become a tick, counted on the third
    always_comb begin
        pre_nxt  = pre_r + 1'b1;
        ext_nxt  = {ext_r[1:0], external_count_input};
        // Only the second and third stages are compared
        // Rising: second stage high, edge stage still low
        if (cfg_r.clock_select_field == TC8_CS_EXTR) begin
            ext_edge = ext_r[1] & ~ext_r[2];
        end else begin
            ext_edge = ~ext_r[1] & ext_r[2];
        end
        // Stopped, external edge or prescaler tap
        unique case (cfg_r.clock_select_field)
            TC8_CS_STOP: timer_tick = 1'b0;
            TC8_CS_EXTF, TC8_CS_EXTR: timer_tick = ext_edge;
            default: timer_tick =
                presc_tick(cfg_r.clock_select_field, pre_r);
        endcase
    end

    // Mode decode and extreme indications
    // Top follows compare A in the compare-top modes
    always_comb begin
        pc_mode   = (cfg_r.waveform_mode_field == TC8_WM_PC_MAX) ||
                    (cfg_r.waveform_mode_field == TC8_WM_PC_CMPA);
        fp_mode   = (cfg_r.waveform_mode_field == TC8_WM_FP_MAX) ||
                    (cfg_r.waveform_mode_field == TC8_WM_FP_CMPA);
        top_val   = top_of(cfg_r.waveform_mode_field, cmpa_r);
        at_top    = (cnt_r == top_val);
        at_bottom = (cnt_r == TC8_BOTTOM);
    end

    // Counter, direction and match blocking
    always_comb begin
        cnt_nxt = cnt_r;
        dir_nxt = dir_r;
        blk_nxt = blk_r;
        if (timer_tick) begin
            blk_nxt = 1'b0;
            if (pc_mode) begin
                // Up to top, then down to bottom
                unique case (dir_r)
                    TC8_UP: begin
                        if (at_top) begin
                            dir_nxt = TC8_DOWN;
                            cnt_nxt = cnt_r - 1'b1;
                        end else begin
                            cnt_nxt = cnt_r + 1'b1;
                        end
                    end
                    TC8_DOWN: begin
                        if (at_bottom) begin
                            dir_nxt = TC8_UP;
                            cnt_nxt = cnt_r + 1'b1;
                        end else begin
                            cnt_nxt = cnt_r - 1'b1;
                        end
                    end
                endcase
            end else begin
                // Up-only modes wrap from top to bottom
                dir_nxt = TC8_UP;
                if (at_top) begin
                    cnt_nxt = TC8_BOTTOM;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
        end
        // Bus write comes last so it beats any tick
        if (wr_en && paddr == TC8_OFS_COUNT) begin
            cnt_nxt = pwdata[7:0];
            // Blocks the match on the next tick
            blk_nxt = 1'b1;
        end
    end

    // Flag events and software writes
    always_comb begin
        set_ev = 3'h0;
        if (timer_tick) begin
            // Overflow point depends on the mode family
            if (pc_mode) begin
                set_ev[TC8_FL_OVF] = at_bottom &&
                                     dir_r == TC8_DOWN;
            end else if (fp_mode) begin
                set_ev[TC8_FL_OVF] = at_top;
            end else begin
                set_ev[TC8_FL_OVF] = (cnt_r == TC8_MAX);
            end
            // Equality seen through the previous tick period
            set_ev[TC8_FL_MA] = (cnt_r == cmpa_r) & ~blk_r;
            set_ev[TC8_FL_MB] = (cnt_r == cmpb_r) & ~blk_r;
        end
        // Service pulses and written ones clear
        clr_ev = int_serviced;
        if (wr_en && paddr == TC8_OFS_FLAG) begin
            clr_ev = clr_ev | pwdata[2:0];
        end
        // Set wins over clear in the same cycle
        flag_nxt = (flag_r & ~clr_ev) | set_ev;
        // Requests follow the new flags and mask
        irq_nxt  = flag_nxt & mask_nxt;
    end

    // Configuration register writes
    always_comb begin
        cfg_nxt  = cfg_r;
        cmpa_nxt = cmpa_r;
        cmpb_nxt = cmpb_r;
        mask_nxt = mask_r;
        // Only a completing write changes configuration
        if (wr_en) begin
            unique case (paddr)
                TC8_OFS_CTRL_A: cfg_nxt.waveform_mode_field[1:0] =
                    pwdata[TC8_WGM_LO_POS +: 2];
                TC8_OFS_CTRL_B: begin
                    cfg_nxt.clock_select_field =
                        pwdata[TC8_CS_POS +: 3];
                    cfg_nxt.waveform_mode_field[2] =
                        pwdata[TC8_WGM_HI_POS];
                end
                TC8_OFS_CMP_A:  cmpa_nxt = pwdata[7:0];
                TC8_OFS_CMP_B:  cmpb_nxt = pwdata[7:0];
                TC8_OFS_MASK:   mask_nxt = pwdata[2:0];
                // Count and flag words handled elsewhere, status is read-only
                default:        ;
            endcase
        end
    end

    // Read data and handshake
    always_comb begin
        // Ready rises one cycle after enable, for one cycle
        rdy_nxt = psel & penable & ~rdy_r;
        err_nxt = rdy_nxt & ~mapped;
        rd_nxt  = rd_r;
        if (rdy_nxt) begin
            // Unused upper bits read as zero
            rd_nxt = 32'h0;
            unique case (paddr)
                TC8_OFS_CTRL_A:
                    rd_nxt[1:0] = cfg_r.waveform_mode_field[1:0];
                TC8_OFS_CTRL_B:
                    rd_nxt[3:0] = {cfg_r.waveform_mode_field[2],
                                   cfg_r.clock_select_field};
                TC8_OFS_COUNT:  rd_nxt[7:0] = cnt_r;
                TC8_OFS_CMP_A:  rd_nxt[7:0] = cmpa_r;
                TC8_OFS_CMP_B:  rd_nxt[7:0] = cmpb_r;
                TC8_OFS_MASK:   rd_nxt[2:0] = mask_r;
                TC8_OFS_FLAG:   rd_nxt[2:0] = flag_r;
                TC8_OFS_STATUS:
                    rd_nxt[2:0] = {dir_r == TC8_DOWN, at_top, at_bottom};
                default:        rd_nxt = 32'h0;
            endcase
        end
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Everything clears except direction, which loads up; counter stopped
            cfg_r  <= '0;
            cnt_r  <= TC8_RST_VAL;
            cmpa_r <= TC8_RST_VAL;
            cmpb_r <= TC8_RST_VAL;
            mask_r <= 3'h0;
            flag_r <= 3'h0;
            dir_r  <= TC8_UP;
            blk_r  <= 1'b0;
            pre_r  <= '0;
            ext_r  <= 3'h0;
            rd_r   <= 32'h0;
            rdy_r  <= 1'b0;
            err_r  <= 1'b0;
            irq_r  <= 3'h0;
        end else begin
            // Plain register update
            cfg_r  <= cfg_nxt;
            cnt_r  <= cnt_nxt;
            cmpa_r <= cmpa_nxt;
            cmpb_r <= cmpb_nxt;
            mask_r <= mask_nxt;
            flag_r <= flag_nxt;
            dir_r  <= dir_nxt;
            blk_r  <= blk_nxt;
            pre_r  <= pre_nxt;
            ext_r  <= ext_nxt;
            rd_r   <= rd_nxt;
            rdy_r  <= rdy_nxt;
            err_r  <= err_nxt;
            irq_r  <= irq_nxt;
        end
    end

    // Outputs straight from flip-flops
    // No logic between the flops and the pins
    always_comb begin
        prdata        = rd_r;
        pready        = rdy_r;
        pslverr       = err_r;
        timer_irq_req = irq_r;
    end
endmodule
`default_nettype wire

// ---- hdl/tc8_pkg.sv ----
// Constants and types for the 8-bit timer/counter core
// Function
// - Count and both compare registers are 8-bit
// - Flags visible, each gated by own mask bit
// - Prescaled or external count source, edge selectable
// - Clock select zero stops the counter
// - Compare both registers continuously, match sets flag
// - Bottom indication when counter holds zero
// - Maximum is all-ones value 255
// - Top is all-ones or compare A by mode
// - Clock select field lives in control B
// - Each tick clears, increments or decrements counter
// - Counter readable and writable at any time
// - Counter write beats clear or count
// - Mode bits split across control A and B
// - Overflow flag set at mode-defined point
// - Three sources: overflow, match A, match B
// - Top indication at sequence highest value
// - Match flag set one tick after equality
// - Flag cleared on service or writing one
// - Normal mode wraps, overflow when becoming zero
package tc8_pkg;
    // Register byte offsets
    localparam logic [7:0] TC8_OFS_CTRL_A  = 8'h00;
    localparam logic [7:0] TC8_OFS_CTRL_B  = 8'h04;
    localparam logic [7:0] TC8_OFS_COUNT   = 8'h08;
    localparam logic [7:0] TC8_OFS_CMP_A   = 8'h0c;
    localparam logic [7:0] TC8_OFS_CMP_B   = 8'h10;
    localparam logic [7:0] TC8_OFS_MASK    = 8'h14;
    localparam logic [7:0] TC8_OFS_FLAG    = 8'h18;
    localparam logic [7:0] TC8_OFS_STATUS  = 8'h1c;
    // Field positions
    localparam int TC8_WGM_LO_POS = 0;   // Mode bits 1:0 in control A
    localparam int TC8_CS_POS     = 0;   // Clock select 2:0 in control B
    localparam int TC8_WGM_HI_POS = 3;   // Mode bit 2 in control B
    localparam int TC8_FL_OVF     = 0;   // Overflow flag/mask bit
    localparam int TC8_FL_MA      = 1;   // Match A flag/mask bit
    localparam int TC8_FL_MB      = 2;   // Match B flag/mask bit
    // Reset value and extremes
    localparam logic [7:0] TC8_RST_VAL = 8'h00;
    localparam logic [7:0] TC8_BOTTOM  = 8'h00;
    localparam logic [7:0] TC8_MAX     = 8'hff;
    // Clock select codes
    localparam logic [2:0] TC8_CS_STOP   = 3'h0;
    localparam logic [2:0] TC8_CS_DIV1   = 3'h1;
    localparam logic [2:0] TC8_CS_DIV8   = 3'h2;
    localparam logic [2:0] TC8_CS_DIV64  = 3'h3;
    localparam logic [2:0] TC8_CS_DIV256 = 3'h4;
    localparam logic [2:0] TC8_CS_DIV1K  = 3'h5;
    localparam logic [2:0] TC8_CS_EXTF   = 3'h6;
    localparam logic [2:0] TC8_CS_EXTR   = 3'h7;
    // Waveform mode codes
    localparam logic [2:0] TC8_WM_NORMAL  = 3'h0;
    localparam logic [2:0] TC8_WM_PC_MAX  = 3'h1;
    localparam logic [2:0] TC8_WM_CTC     = 3'h2;
    localparam logic [2:0] TC8_WM_FP_MAX  = 3'h3;
    localparam logic [2:0] TC8_WM_PC_CMPA = 3'h5;
    localparam logic [2:0] TC8_WM_FP_CMPA = 3'h7;
    // Prescaler width for the largest divider
    localparam int TC8_PRE_W = 10;
    // Count direction, one-hot
    typedef enum logic [1:0] {
        TC8_UP   = 2'b01,
        TC8_DOWN = 2'b10
    } tc8_dir_e;
    // Control fields carried together
    typedef struct packed {
        logic [2:0] clock_select_field;
        logic [2:0] waveform_mode_field;
    } tc8_cfg_s;
endpackage

// ---- verif/tc8_core_props.sv ----
// Port checker for the timer/counter core bus and request outputs
`timescale 1ns/1ps
`default_nettype none
module tc8_core_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        external_count_input,
    input wire logic [2:0]  int_serviced,
    input wire logic [2:0]  timer_irq_req
);
    // One domain, so clock and reset are shared by all
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Ready is a single-cycle pulse
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    // Ready comes in the second access cycle
    a_ready_timing: assert property ((psel && !penable) ##1
        (psel && penable) |=> pready) else $error("ready late");
    // Ready only inside an access
    a_ready_source: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    // Reads above the last word are refused with zero data
    a_err_unmapped: assert property (pready && !pwrite &&
        paddr > 8'h1c |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    // Mapped words answer without error
    a_err_mapped: assert property (pready && paddr <= 8'h1c &&
        paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped error");
    // Registers are one byte wide
    a_rdata_width: assert property (pready && !pwrite |->
        prdata[31:8] == 24'h0) else $error("upper read bits set");
    // A cleared mask bit silences its request
    a_mask_gate: assert property (pready && pwrite &&
        paddr == 8'h14 |=> (timer_irq_req & ~$past(pwdata[2:0])) == 3'h0)
        else $error("masked request still high");
    // No request right after reset
    a_irq_reset: assert property ($rose(presetn) |->
        timer_irq_req == 3'h0) else $error("request after reset");
endmodule
bind tc8_core tc8_core_props u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_input(external_count_input),
    .int_serviced(int_serviced), .timer_irq_req(timer_irq_req));
`default_nettype wire

// ---- verif/test_eight_bit_timer_counter_core.sv ----
// Self-checking bench for the timer/counter core
`timescale 1ns/1ps
`default_nettype none
module test_eight_bit_timer_counter_core;
    import tc8_pkg::*;
    logic        pclk    = 1'b0;  // System clock
    logic        presetn = 1'b0;  // Reset, active low
    logic        psel    = 1'b0;  // Bus select
    logic        penable = 1'b0;  // Bus enable
    logic        pwrite  = 1'b0;  // Bus direction
    logic [7:0]  paddr   = 8'h00; // Bus address
    logic [31:0] pwdata  = 32'h0; // Bus write data
    logic [31:0] prdata;          // Bus read data
    logic        pready;          // Bus ready
    logic        pslverr;         // Bus error
    logic        ext_pin = 1'b0;  // Count pin drive
    logic [2:0]  svc     = 3'h0;  // Service pulses
    logic [2:0]  irq;             // Masked requests
    logic [31:0] rd;              // Last read data
    logic        er;              // Last error flag
    int error_cnt = 0;
    int check_count = 0;
    int cnt, top, fl, blk, md, msk, ca, cb, lo; // Reference model state
    int dir = 0;                  // Model direction, 1 when counting down
    int modes[6] = '{0, 2, 3, 7, 1, 5};
    tc8_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_input(ext_pin),
        .int_serviced(svc), .timer_irq_req(irq));
    // Clock at 50 ns period
    initial begin
        forever #25 pclk = ~pclk;
    end
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic report_and_stop();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // One bus transfer, held until ready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            error_cnt++;
            report_and_stop();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // One full pin pulse, long enough for the synchroniser
    task automatic pulse();
        @(posedge pclk);
        ext_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_pin <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    // Model of one timer tick
    task automatic tick();
        int pc;
        pc = (md == 1 || md == 5) ? 1 : 0;
        if (pc != 0) begin
            if (cnt == 0 && dir == 1) fl |= 1;
        end else if ((md == 3 || md == 7) ? cnt == top : cnt == 255) begin
            fl |= 1;
        end
        if (blk == 0 && cnt == ca) fl |= 2;
        if (blk == 0 && cnt == cb) fl |= 4;
        blk = 0;
        if (pc == 0) begin
            dir = 0;
            cnt = (cnt == top) ? 0 : (cnt + 1) & 255;
        end else if (dir == 0) begin
            dir = (cnt == top) ? 1 : 0;
            cnt = (cnt + ((dir == 1) ? 255 : 1)) & 255;
        end else begin
            dir = (cnt == 0) ? 0 : 1;
            cnt = (cnt + ((dir == 0) ? 1 : 255)) & 255;
        end
    endtask
    // Hang guard
    initial begin
        #2000000;
        error_cnt++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        int i, k, n;
        void'($urandom(78013));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, then the unmapped word
        for (i = 0; i <= 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, (i == 7) ? 32'h1 : 32'h0);
            chk({31'h0, er}, (i == 8) ? 32'h1 : 32'h0);
        end
        // Stopped counter ignores the pin, stays writable
        apb(1'b1, TC8_OFS_COUNT, 32'h42);
        pulse();
        pulse();
        apb(1'b0, TC8_OFS_COUNT, 32'h0);
        chk(rd, 32'h42);
        // Write lands while a tick runs every cycle, then four more ticks
        apb(1'b1, TC8_OFS_CTRL_B, {29'h0, TC8_CS_DIV1});
        apb(1'b1, TC8_OFS_COUNT, 32'h10);
        apb(1'b1, TC8_OFS_CTRL_B, 32'h0);
        apb(1'b0, TC8_OFS_COUNT, 32'h0);
        chk(rd, 32'h14);
        // Each mode counts pin edges near the wrap point
        for (k = 0; k < 6; k++) begin
            md = modes[k];
            lo = (md == 5) ? 0 : 250;  // Low start so the bounce hits zero
            ca = lo + 2 + $urandom_range(3, 0);
            cb = lo + $urandom_range(5, 0);
            cnt = lo + $urandom_range(3, 0);
            top = (md == 2 || md == 5 || md == 7) ? ca : 255;
            msk = $urandom_range(7, 0);
            fl = 0;
            blk = 1;
            apb(1'b1, TC8_OFS_CTRL_B, 32'h0);
            apb(1'b1, TC8_OFS_CTRL_A, md & 3);
            apb(1'b1, TC8_OFS_COUNT, cnt);
            apb(1'b1, TC8_OFS_CMP_A, ca);
            apb(1'b1, TC8_OFS_CMP_B, cb);
            apb(1'b1, TC8_OFS_FLAG, 32'h7);
            apb(1'b1, TC8_OFS_MASK, msk);
            // Falling or rising pin edge, by turns
            apb(1'b1, TC8_OFS_CTRL_B, ((md >> 2) << 3) | (6 + (k & 1)));
            n = 4 + $urandom_range(6, 0);
            for (i = 0; i < n; i++) begin
                pulse();
                tick();
            end
            apb(1'b0, TC8_OFS_COUNT, 32'h0);
            chk(rd, cnt);
            apb(1'b0, TC8_OFS_FLAG, 32'h0);
            chk(rd, fl);
            chk({29'h0, irq}, fl & msk);
            apb(1'b0, TC8_OFS_STATUS, 32'h0);
            chk(rd, (dir << 2) | ((cnt == top) << 1) | (cnt == 0));
        end
        // Service clears overflow and match B, a written one match A
        apb(1'b1, TC8_OFS_CTRL_B, 32'h0);
        @(posedge pclk);
        svc <= 3'h5;
        @(posedge pclk);
        svc <= 3'h0;
        fl &= 2;
        apb(1'b0, TC8_OFS_FLAG, 32'h0);
        chk(rd, fl);
        apb(1'b1, TC8_OFS_FLAG, 32'h2);
        apb(1'b0, TC8_OFS_FLAG, 32'h0);
        chk(rd, 32'h0);
        chk({29'h0, irq}, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
